// file: hdl/dmtr_pkg.sv
// package: data memory map, field layout and table read constants
package dmtr_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PM_ADDR_W = 11;
  localparam int unsigned PM_DATA_W = 15;
  localparam int unsigned TBL_HI_W = PM_DATA_W - DATA_W;
  // special function map
  localparam logic [7:0] ADR_IND0 = 8'h00;
  localparam logic [7:0] ADR_MPTR0 = 8'h01;
  localparam logic [7:0] ADR_IND1 = 8'h02;
  localparam logic [7:0] ADR_MPTR1 = 8'h03;
  localparam logic [7:0] ADR_BANK = 8'h04;
  localparam logic [7:0] ADR_ALU = 8'h05;
  localparam logic [7:0] ADR_PCLO = 8'h06;
  localparam logic [7:0] ADR_TPTR = 8'h07;
  localparam logic [7:0] ADR_THI = 8'h08;
  localparam logic [7:0] ADR_FLAG = 8'h0A;
  localparam logic [7:0] ADR_UNUSED = 8'h0C;
  localparam logic [7:0] ADR_EECTL = 8'h40;
  // first general purpose location; others below it belong to other blocks
  localparam logic [7:0] ADR_GP_BASE = 8'h41;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BANK_MASK = 8'h01;
  localparam logic [7:0] FLAG_WR_MASK = 8'h0F;
  localparam logic [7:0] FLAG_RO_MASK = 8'h30;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam int unsigned RAM_DEPTH = 512;
  localparam int unsigned RAM_AW = 9;
  // plain write and read-modify-write operations of the core
  typedef enum logic [1:0] {
    DMTR_OP_WR = 2'h0,
    DMTR_OP_SET = 2'h1,
    DMTR_OP_CLR = 2'h2
  } dmtr_op_t;
  // table read sequencer, gray along idle -> fetch -> load
  typedef enum logic [1:0] {
    DMTR_T_IDLE = 2'h0,
    DMTR_T_FETCH = 2'h1,
    DMTR_T_LOAD = 2'h3
  } dmtr_tstate_t;
endpackage : dmtr_pkg

// file: hdl/dmtr_ram_if.sv
// interface: general purpose ram port between decoder and memory
interface dmtr_ram_if;
  logic we;
  logic [dmtr_pkg::RAM_AW-1:0] waddr;
  logic [dmtr_pkg::RAM_AW-1:0] raddr;
  logic [dmtr_pkg::DATA_W-1:0] wdata;
  logic [dmtr_pkg::DATA_W-1:0] rdata;
  modport ctrl (output we, output waddr, output raddr, output wdata, input rdata);
  modport mem (input we, input waddr, input raddr, input wdata, output rdata);
endinterface : dmtr_ram_if

// file: hdl/dmtr_ram.sv
// general purpose data ram, two banks, registered read
module dmtr_ram (
  input wire logic sys_clk_i,
  dmtr_ram_if.mem port
);
  logic [dmtr_pkg::DATA_W-1:0] mem_reg [dmtr_pkg::RAM_DEPTH];
  logic [dmtr_pkg::DATA_W-1:0] rdata_reg;

  // no reset on the array; contents are undefined at power up
  always_ff @(posedge sys_clk_i) begin
    if (port.we) begin
      mem_reg[port.waddr] <= port.wdata;
    end
    rdata_reg <= mem_reg[port.raddr];
  end

  assign port.rdata = rdata_reg;
endmodule : dmtr_ram

// file: hdl/dmtr_core.sv
// data memory decoder, indirect ports and table read unit
//
// Behaviour
// - current-page table read: address is pc high bits plus table pointer
// - last-page table read: address is 0700h plus table pointer
// - each table read loads the word's high part into table high byte
// - table high byte is read-only; software writes are dropped
// - table reads take two cycles; busy stalls the core meanwhile
// - locations are 8 bits wide, address space starts at 00h
// - bit set and clear reach any bit except protected ones
// - protected special locations keep their state on writes
// - general purpose locations are read and write
// - special registers same in both banks; 40h only in bank 1
// - selected bank follows the bank select register
// - indirect ports hold no storage; they act via their pointer
// - port 0 uses pointer 0, port 1 uses pointer 1
// - indirect access to a port address reads 00h, writes nothing
// - special map 00h..08h as listed, flags at 0ah
// - unused table high byte bits read zero
// - low byte of the fetched word goes to the operand location if it is a pointer, alu, table pointer or ram
// - port 0 always bank 0; port 1 follows bank select
// - direct addressing reaches bank 0 except at 40h, which follows bank select
module dmtr_core (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic [1:0] acc_op_i,
  input wire logic [2:0] acc_bit_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic tbl_req_i,
  input wire logic tbl_last_i,
  input wire logic [7:0] tbl_dest_i,
  input wire logic [2:0] pc_high_i,
  input wire logic [14:0] pm_rdata_i,
  input wire logic [3:0] flag_hw_i,
  input wire logic flag_hw_we_i,
  input wire logic [1:0] sys_flags_i,
  output logic [7:0] acc_rdata_o,
  output logic acc_rvalid_o,
  output logic busy_o,
  output logic [10:0] pm_addr_o,
  output logic pm_re_o,
  output logic [7:0] alu_result_o,
  output logic [7:0] pcl_o,
  output logic pcl_wr_o,
  output logic bank_o,
  output logic eectl_sel_o
);
  typedef struct packed {
    logic [7:0] mptr0;
    logic [7:0] mptr1;
    logic [7:0] bank;
    logic [7:0] alu;
    logic [7:0] pclo;
    logic [7:0] tptr;
    logic [7:0] thi;
    logic [7:0] flags;
    dmtr_pkg::dmtr_tstate_t tst;
    logic [7:0] tdest;
    logic [10:0] pm_addr;
    logic pm_re;
    logic [7:0] rdata;
    logic rvalid;
    logic rd_ram;
    logic pcl_wr;
    logic eesel;
  } dmtr_state_t;

  dmtr_state_t st_reg;
  dmtr_state_t st_next;
  dmtr_ram_if ram ();

  dmtr_ram u_ram (
    .sys_clk_i(sys_clk_i),
    .port(ram.mem)
  );

  ////////////////////////////////////////////////////////////////////
  // address resolution
  logic ind_sel;
  logic ind_is0;
  logic [7:0] eff_addr;
  logic eff_bank;
  logic ind_self;
  logic [7:0] sfr_val;
  logic sfr_hit;
  logic is_gp;
  logic [7:0] new_val;
  logic [7:0] bit_mask;

  always_comb begin
    ind_is0 = (acc_addr_i == dmtr_pkg::ADR_IND0);
    ind_sel = ind_is0 || (acc_addr_i == dmtr_pkg::ADR_IND1);
    // port k follows its own pointer
    eff_addr = ind_is0 ? st_reg.mptr0 : (ind_sel ? st_reg.mptr1 : acc_addr_i);
    // direct and port 0 stay in bank 0; port 1 honours bank select
    eff_bank = (ind_sel && !ind_is0) ? st_reg.bank[0] : 1'b0;
    ind_self = ind_sel && ((eff_addr == dmtr_pkg::ADR_IND0) ||
                           (eff_addr == dmtr_pkg::ADR_IND1));
    is_gp = (eff_addr >= dmtr_pkg::ADR_GP_BASE);
    bit_mask = 8'h01 << acc_bit_i;
  end

  // special register read mux; banks alias apart from 40h
  always_comb begin
    sfr_hit = 1'b1;
    sfr_val = dmtr_pkg::ZERO_BYTE;
    case (eff_addr)
      dmtr_pkg::ADR_MPTR0: sfr_val = st_reg.mptr0;
      dmtr_pkg::ADR_MPTR1: sfr_val = st_reg.mptr1;
      dmtr_pkg::ADR_BANK: sfr_val = st_reg.bank & dmtr_pkg::BANK_MASK;
      dmtr_pkg::ADR_ALU: sfr_val = st_reg.alu;
      dmtr_pkg::ADR_PCLO: sfr_val = st_reg.pclo;
      dmtr_pkg::ADR_TPTR: sfr_val = st_reg.tptr;
      dmtr_pkg::ADR_THI: sfr_val = st_reg.thi;
      dmtr_pkg::ADR_FLAG: sfr_val = st_reg.flags;
      default: sfr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.rd_ram = 1'b0;
    st_next.pcl_wr = 1'b0;
    st_next.pm_re = 1'b0;
    st_next.eesel = 1'b0;
    ram.we = 1'b0;
    ram.waddr = {eff_bank, eff_addr};
    ram.raddr = {eff_bank, eff_addr};
    ram.wdata = acc_wdata_i;
    new_val = acc_wdata_i;
    // hardware flag update from the alu
    if (flag_hw_we_i) begin
      st_next.flags[3:0] = flag_hw_i;
    end
    // protected flags mirror system state, never software
    st_next.flags[5:4] = sys_flags_i;
    st_next.flags[7:6] = 2'h0;
    case (st_reg.tst)
      dmtr_pkg::DMTR_T_IDLE: begin
        if (tbl_req_i) begin
          st_next.tdest = tbl_dest_i;
          st_next.pm_addr = tbl_last_i ? {dmtr_pkg::LAST_PAGE, st_reg.tptr}
                                       : {pc_high_i, st_reg.tptr};
          st_next.pm_re = 1'b1;
          st_next.tst = dmtr_pkg::DMTR_T_FETCH;
        end else if (acc_req_i && !acc_wr_i) begin
          // reads answer one cycle later
          st_next.rvalid = 1'b1;
          st_next.rd_ram = is_gp && !ind_self;
          st_next.rdata = ind_self ? dmtr_pkg::ZERO_BYTE : sfr_val;
          // 40h decodes through the bank select, port 0 never leaves bank 0
          st_next.eesel = (eff_addr == dmtr_pkg::ADR_EECTL) && !ind_is0 && st_reg.bank[0];
        end else if (acc_req_i && acc_wr_i && !ind_self) begin
          // special registers modify their own value; ram bits modify the
          // current value that the core hands in, as ram reads take a cycle
          if (acc_op_i == dmtr_pkg::DMTR_OP_SET) begin
            new_val = (sfr_hit ? sfr_val : acc_wdata_i) | bit_mask;
          end else if (acc_op_i == dmtr_pkg::DMTR_OP_CLR) begin
            new_val = (sfr_hit ? sfr_val : acc_wdata_i) & ~bit_mask;
          end
          st_next.eesel = (eff_addr == dmtr_pkg::ADR_EECTL) && !ind_is0 && st_reg.bank[0];
          case (eff_addr)
            dmtr_pkg::ADR_MPTR0: st_next.mptr0 = new_val;
            dmtr_pkg::ADR_MPTR1: st_next.mptr1 = new_val;
            dmtr_pkg::ADR_BANK: st_next.bank = new_val & dmtr_pkg::BANK_MASK;
            dmtr_pkg::ADR_ALU: st_next.alu = new_val;
            dmtr_pkg::ADR_PCLO: begin
              st_next.pclo = new_val;
              st_next.pcl_wr = 1'b1;
            end
            dmtr_pkg::ADR_TPTR: st_next.tptr = new_val;
            dmtr_pkg::ADR_THI: st_next.thi = st_reg.thi;
            dmtr_pkg::ADR_FLAG: begin
              st_next.flags = (st_reg.flags & ~dmtr_pkg::FLAG_WR_MASK) |
                              (new_val & dmtr_pkg::FLAG_WR_MASK);
              st_next.flags[5:4] = sys_flags_i;
            end
            default: begin
              // general purpose store; bit ops on ram need a prior read
              ram.we = is_gp;
              ram.wdata = new_val;
            end
          endcase
        end
      end
      dmtr_pkg::DMTR_T_FETCH: begin
        // program word is read now and arrives in load; stall holds the core
        st_next.tst = dmtr_pkg::DMTR_T_LOAD;
      end
      dmtr_pkg::DMTR_T_LOAD: begin
        st_next.thi = {1'b0, pm_rdata_i[dmtr_pkg::PM_DATA_W-1:dmtr_pkg::DATA_W]};
        // low byte to the operand, direct so bank 0
        ram.waddr = {1'b0, st_reg.tdest};
        ram.wdata = pm_rdata_i[dmtr_pkg::DATA_W-1:0];
        ram.we = (st_reg.tdest >= dmtr_pkg::ADR_GP_BASE);
        case (st_reg.tdest)
          dmtr_pkg::ADR_MPTR0: st_next.mptr0 = pm_rdata_i[7:0];
          dmtr_pkg::ADR_MPTR1: st_next.mptr1 = pm_rdata_i[7:0];
          dmtr_pkg::ADR_ALU: st_next.alu = pm_rdata_i[7:0];
          dmtr_pkg::ADR_TPTR: st_next.tptr = pm_rdata_i[7:0];
          default: st_next.alu = st_reg.alu;
        endcase
        st_next.tst = dmtr_pkg::DMTR_T_IDLE;
      end
      default: st_next.tst = dmtr_pkg::DMTR_T_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0; // bank 0 after reset
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs; ram data is already registered inside the memory
  logic [7:0] rdata_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= dmtr_pkg::ZERO_BYTE;
    end else begin
      rdata_q <= st_next.rd_ram ? dmtr_pkg::ZERO_BYTE : st_next.rdata;
    end
  end

  assign acc_rdata_o = st_reg.rd_ram ? ram.rdata : rdata_q;
  assign acc_rvalid_o = st_reg.rvalid;
  assign busy_o = (st_reg.tst != dmtr_pkg::DMTR_T_IDLE);
  assign pm_addr_o = st_reg.pm_addr;
  assign pm_re_o = st_reg.pm_re;
  assign alu_result_o = st_reg.alu;
  assign pcl_o = st_reg.pclo;
  assign pcl_wr_o = st_reg.pcl_wr;
  assign bank_o = st_reg.bank[0];
  assign eectl_sel_o = st_reg.eesel;
endmodule : dmtr_core

// file: testbench/dmtr_core_assertions.sv
// checker: port-level timing and decode assertions for the data memory core
module dmtr_core_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic [1:0] acc_op_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic tbl_req_i,
  input wire logic tbl_last_i,
  input wire logic [2:0] pc_high_i,
  input wire logic acc_rvalid_o,
  input wire logic busy_o,
  input wire logic [10:0] pm_addr_o,
  input wire logic pm_re_o,
  input wire logic [7:0] alu_result_o,
  input wire logic [7:0] pcl_o,
  input wire logic pcl_wr_o,
  input wire logic bank_o,
  input wire logic eectl_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // table read wins over a data access on the same edge
  wire take_acc = acc_req_i && !busy_o && !tbl_req_i;
  wire take_tbl = tbl_req_i && !busy_o;
  wire wr_plain = take_acc && acc_wr_i && acc_op_i == 2'h0;
  wire wdata_lsb = acc_wdata_i[0];
  sequence tbl_stall;
    busy_o [*2] ##1 !busy_o;
  endsequence
  sequence tbl_fetch;
    pm_re_o ##1 !pm_re_o;
  endsequence
  a_read_answer: assert property (take_acc && !acc_wr_i |=> acc_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (acc_rvalid_o |-> $past(take_acc) && !$past(acc_wr_i))
    else $error("read valid without a read");
  a_table_stall: assert property (take_tbl |=> tbl_stall)
    else $error("table read stall length wrong");
  a_table_fetch: assert property (take_tbl |=> tbl_fetch)
    else $error("program fetch pulse wrong");
  a_last_page: assert property (take_tbl && tbl_last_i |=> pm_addr_o[10:8] == 3'h7)
    else $error("last page base wrong");
  a_current_page: assert property (take_tbl && !tbl_last_i |=> pm_addr_o[10:8] == $past(pc_high_i))
    else $error("current page base wrong");
  a_bank_follow: assert property (wr_plain && acc_addr_i == 8'h04 |=> bank_o == $past(wdata_lsb))
    else $error("bank select not followed");
  a_alu_load: assert property (wr_plain && acc_addr_i == 8'h05 |=> alu_result_o == $past(acc_wdata_i))
    else $error("alu register not loaded");
  a_pcl_jump: assert property (wr_plain && acc_addr_i == 8'h06 |=> pcl_wr_o && pcl_o == $past(acc_wdata_i))
    else $error("pcl write not signalled");
  a_eectl_bank1: assert property (eectl_sel_o |-> $past(bank_o) &&
    ($past(acc_addr_i) == 8'h40 || $past(acc_addr_i) == 8'h02))
    else $error("eeprom control decoded outside bank 1");
endmodule : dmtr_core_assertions

bind dmtr_core dmtr_core_assertions u_chk (.sys_clk_i, .rst_n_i, .acc_req_i, .acc_wr_i, .acc_op_i,
  .acc_addr_i, .acc_wdata_i, .tbl_req_i, .tbl_last_i, .pc_high_i, .acc_rvalid_o, .busy_o,
  .pm_addr_o, .pm_re_o, .alu_result_o, .pcl_o, .pcl_wr_o, .bank_o, .eectl_sel_o);

// file: testbench/dmtr_pm_model.sv
// partner: program memory answering table fetches
module dmtr_pm_model (
  input wire logic sys_clk_i,
  input wire logic pm_re_i,
  input wire logic [10:0] pm_addr_i,
  output logic [14:0] pm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pm_rdata_o = 15'h0000;
  // word valid one cycle; outside it the bus toggles so stale data cannot pass
  always @(posedge sys_clk_i) begin
    if (pm_re_i) pm_rdata_o <= {pm_addr_i[10:4], pm_addr_i[7:0] ^ 8'h3C};
    else pm_rdata_o <= ~pm_rdata_o;
  end
endmodule : dmtr_pm_model

// file: testbench/data_memory_and_table_read_tb_top.sv
// testbench: directed scenarios for the data memory core
module data_memory_and_table_read_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, acc_req_i = 1'b0, acc_wr_i = 1'b0;
  logic tbl_req_i = 1'b0, tbl_last_i = 1'b0, flag_hw_we_i = 1'b0;
  logic [1:0] acc_op_i = 2'h0, sys_flags_i = 2'h0;
  logic [2:0] acc_bit_i = 3'h0, pc_high_i = 3'h0;
  logic [7:0] acc_addr_i = 8'h00, acc_wdata_i = 8'h00, tbl_dest_i = 8'h00;
  logic [3:0] flag_hw_i = 4'h0;
  logic [14:0] pm_rdata_i;
  logic [7:0] acc_rdata_o, alu_result_o, pcl_o;
  logic [10:0] pm_addr_o;
  logic acc_rvalid_o, busy_o, pm_re_o, pcl_wr_o, bank_o, eectl_sel_o;
  int num_errors = 0, tests_run = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  dmtr_core DUT (.sys_clk_i, .rst_n_i, .acc_req_i, .acc_wr_i, .acc_op_i, .acc_bit_i, .acc_addr_i,
    .acc_wdata_i, .tbl_req_i, .tbl_last_i, .tbl_dest_i, .pc_high_i, .pm_rdata_i, .flag_hw_i,
    .flag_hw_we_i, .sys_flags_i, .acc_rdata_o, .acc_rvalid_o, .busy_o, .pm_addr_o, .pm_re_o,
    .alu_result_o, .pcl_o, .pcl_wr_o, .bank_o, .eectl_sel_o);
  dmtr_pm_model u_pm (.sys_clk_i, .pm_re_i(pm_re_o), .pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge sys_clk_i);
    #1;
  endtask : step
  // idle cycle first, so a request is never lowered and raised in one time step
  task automatic acc(input logic w, input logic [1:0] op, input logic [2:0] b,
                     input logic [7:0] a, input logic [7:0] d);
    step();
    acc_req_i = 1'b1;
    acc_wr_i = w;
    acc_op_i = op;
    acc_bit_i = b;
    acc_addr_i = a;
    acc_wdata_i = d;
    step();
    acc_req_i = 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, 2'h0, 3'h0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, 2'h0, 3'h0, a, 8'h00);
    chk(acc_rvalid_o, 1'b1);
    chk(acc_rdata_o, exp);
  endtask : rd
  task automatic tbl(input logic last, input logic [2:0] pc, input logic [7:0] tp,
                     input logic [7:0] dest, input logic [10:0] exp);
    wr(8'h07, tp);
    step();
    tbl_req_i = 1'b1;
    tbl_last_i = last;
    pc_high_i = pc;
    tbl_dest_i = dest;
    step();
    tbl_req_i = 1'b0;
    chk(pm_re_o, 1'b1);
    chk(pm_addr_o, exp);
    chk(busy_o, 1'b1);
    step();
    chk(busy_o, 1'b1);
    step();
    chk(busy_o, 1'b0);
    rd(8'h08, {1'b0, exp[10:4]});
    rd(dest, exp[7:0] ^ 8'h3C);
  endtask : tbl
  ////////////////////////////////////////////////////////////////
  task automatic t_special;
    wr(8'h05, 8'hC3);
    rd(8'h05, 8'hC3);
    wr(8'h0C, 8'h5A);
    rd(8'h0C, 8'h00);
    sys_flags_i = 2'h2;
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h2F);
    acc(1'b1, 2'h1, 3'h6, 8'h0A, 8'h00);
    rd(8'h0A, 8'h2F);
    flag_hw_i = 4'h5;
    flag_hw_we_i = 1'b1;
    step();
    flag_hw_we_i = 1'b0;
    rd(8'h0A, 8'h25);
    wr(8'h06, 8'h9A);
    $display("special registers done");
  endtask : t_special
  // port 1 reaches bank 1 while port 0 and direct stay in bank 0
  task automatic t_indirect;
    wr(8'h01, 8'h41);
    wr(8'h00, 8'h55);
    wr(8'h04, 8'h01);
    wr(8'h03, 8'h41);
    wr(8'h02, 8'hAA);
    rd(8'h00, 8'h55);
    rd(8'h41, 8'h55);
    rd(8'h02, 8'hAA);
    acc(1'b0, 2'h0, 3'h0, 8'h40, 8'h00);
    chk(eectl_sel_o, 1'b1);
    wr(8'h04, 8'h00);
    rd(8'h02, 8'h55);
    rd(8'h40, 8'h00);
    chk(eectl_sel_o, 1'b0);
    wr(8'h01, 8'h02);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h77);
    wr(8'h03, 8'h41);
    rd(8'h02, 8'h55);
    $display("indirect access done");
  endtask : t_indirect
  task automatic t_bits;
    wr(8'h42, 8'h0F);
    rd(8'h42, 8'h0F);
    acc(1'b1, 2'h1, 3'h7, 8'h42, 8'h0F);
    rd(8'h42, 8'h8F);
    acc(1'b1, 2'h2, 3'h0, 8'h42, 8'h8F);
    rd(8'h42, 8'h8E);
    $display("bit operations done");
  endtask : t_bits
  task automatic t_table;
    tbl(1'b1, 3'h2, 8'h06, 8'h43, 11'h706);
    tbl(1'b0, 3'h3, 8'hF0, 8'h44, 11'h3F0);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h3F);
    $display("table reads done");
  endtask : t_table
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_special();
    t_indirect();
    t_bits();
    t_table();
    conclude();
  end
endmodule : data_memory_and_table_read_tb_top
